// ==== rtl/csf_consts.vh ====
`ifndef CSF_CONSTS_VH
`define CSF_CONSTS_VH

// register indices (low byte of the special-function address)
`define CSF_IDX_STACK_TOP_UPPER 8'hff
`define CSF_IDX_STACK_TOP_HIGH 8'hfe
`define CSF_IDX_STACK_TOP_LOW 8'hfd
`define CSF_IDX_RETURN_STACK_PTR 8'hfc
`define CSF_IDX_PC_UPPER_LATCH 8'hfb
`define CSF_IDX_PC_HIGH_LATCH 8'hfa
`define CSF_IDX_PC_LOW_BYTE 8'hf9
`define CSF_IDX_TABLE_PTR_UPPER 8'hf8
`define CSF_IDX_TABLE_PTR_HIGH 8'hf7
`define CSF_IDX_TABLE_PTR_LOW 8'hf6
`define CSF_IDX_TABLE_LATCH 8'hf5
`define CSF_IDX_PRODUCT_HIGH 8'hf4
`define CSF_IDX_PRODUCT_LOW 8'hf3
`define CSF_IDX_INT_CTRL_MAIN 8'hf2
`define CSF_IDX_INT_CTRL_SECOND 8'hf1
`define CSF_IDX_INT_CTRL_THIRD 8'hf0
`define CSF_IDX_PLAIN_PORT_ZERO 8'hef
`define CSF_IDX_AFTER_INC_PORT_ZERO 8'hee
`define CSF_IDX_AFTER_DEC_PORT_ZERO 8'hed
`define CSF_IDX_PTR0_HIGH 8'hea
`define CSF_IDX_PTR0_LOW 8'he9
`define CSF_IDX_WORKING_ACC 8'he8

// byte address layout: index sits in bits 9:2, above must be zero
`define CSF_IDX_MSB 9
`define CSF_IDX_LSB 2
`define CSF_ADDR_TOP_LSB 10

// implemented-bit masks
`define CSF_MASK_STACK_TOP_UPPER 8'h1f
`define CSF_MASK_PC_UPPER_LATCH 8'h1f
`define CSF_MASK_TABLE_PTR_UPPER 8'h3f
`define CSF_MASK_STACK_LEVEL 5'h1f
`define CSF_MASK_PTR_HIGH 4'hf

// field positions
`define CSF_STACK_FULL_BIT 7
`define CSF_STACK_UNDER_BIT 6
`define CSF_TABLE_CFG_BIT 5

// reset values
`define CSF_RST_BYTE 8'h00
`define CSF_RST_INT_CTRL_SECOND 8'hff
`define CSF_RST_LEVEL 5'h00
`define CSF_RST_PTR_HIGH 4'h0

// pointer step and bus answer
`define CSF_PTR_STEP 12'h001
`define CSF_RESP_OKAY 2'b00

`endif

// ==== rtl/csf_dmem.v ====
`timescale 1ns/100ps
// data memory behind the indirect ports, one address for read and write
module csf_dmem #(
  parameter AW = 12,
  parameter DEPTH = 4096
) (
  // clock
  input wire clk,
  // access
  input wire we,
  input wire [AW-1:0] addr,
  input wire [7:0] wdata,
  output reg [7:0] rdata
);

  // storage array
  reg [7:0] mem [0:DEPTH-1];

  // read first, read data registered every cycle, old byte on a write
  always @(posedge clk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule

// ==== rtl/csf_top.v ====
// Function
// (RL1) empty locations read zero, writes ignored
// (RL2) variant-absent registers read zero like empty; SMALL_VARIANT is unused, every register stays present
// (RL3) after-increment port: access, then pointer plus one
// (RL4) after-decrement port: access, then pointer minus one
// (RL5) indirect ports hold nothing, reach data memory
// (RL6) table pointer bit 21 selects configuration space
// (RL7) pointer address: four high bits, eight low
`timescale 1ns/100ps
`include "csf_consts.vh"
module csf_top #(
  parameter AW = 12,
  parameter DEPTH = 4096,
  parameter SMALL_VARIANT = 0
) (
  // clock and reset
  input wire SYS_CLK,
  input wire RESETN,
  // axi4-lite write address
  input wire [11:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output wire S_AXI_AWREADY,
  // axi4-lite write data
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output wire S_AXI_WREADY,
  // axi4-lite write response
  output wire [1:0] S_AXI_BRESP,
  output wire S_AXI_BVALID,
  input wire S_AXI_BREADY,
  // axi4-lite read address
  input wire [11:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output wire S_AXI_ARREADY,
  // axi4-lite read data
  output wire [31:0] S_AXI_RDATA,
  output wire [1:0] S_AXI_RRESP,
  output wire S_AXI_RVALID,
  input wire S_AXI_RREADY,
  // stack event pulses from the core
  input wire STACK_FULL_SET,
  input wire STACK_UNDER_SET,
  // table access steering
  output wire [20:0] TABLE_ADDR,
  output wire TABLE_CFG_SEL
);

  // read path states, one-hot
  localparam RD_IDLE = 3'b001;
  localparam RD_MEM = 3'b010;
  localparam RD_RESP = 3'b100;

  // bus handshake state
  reg aw_ready_reg; // write address slot free
  reg w_ready_reg; // write data slot free
  reg bvalid_reg; // write answer pending
  reg [2:0] rd_state_reg; // read sequencer
  reg rvalid_reg; // read answer pending
  reg arready_reg; // read address slot free
  reg [31:0] rdata_reg; // read answer data
  reg [11:0] aw_addr_reg; // held write address
  reg [7:0] w_byte_reg; // held write byte
  reg w_lane_reg; // low byte lane enabled
  reg [11:0] ar_addr_reg; // held read address

  // core registers
  reg [7:0] stack_top_upper_reg;
  reg [7:0] stack_top_high_reg;
  reg [7:0] stack_top_low_reg;
  reg stack_full_flag_reg; // set by core, cleared by writing zero
  reg stack_underflow_flag_reg; // set by core, cleared by writing zero
  reg [4:0] stack_level_reg;
  reg [7:0] pc_upper_latch_reg;
  reg [7:0] pc_high_latch_reg;
  reg [7:0] pc_low_byte_reg;
  reg [7:0] table_pointer_upper_reg;
  reg [7:0] table_pointer_high_reg;
  reg [7:0] table_pointer_low_reg;
  reg [7:0] table_latch_reg;
  reg [7:0] product_high_reg;
  reg [7:0] product_low_reg;
  reg [7:0] interrupt_control_main_reg;
  reg [7:0] interrupt_control_second_reg;
  reg [7:0] interrupt_control_third_reg;
  reg [3:0] ptr0_high_reg; // only four high bits exist
  reg [7:0] ptr0_low_reg;
  reg [7:0] working_accumulator_reg;

  // decode and next values
  wire [7:0] wr_idx; // write index
  wire [7:0] rd_idx; // read index
  wire wr_mapped; // write inside the register window
  wire rd_mapped; // read inside the register window
  wire ar_hs; // read address taken this cycle
  wire wr_fire; // write carried out this cycle
  wire wr_en; // byte really written
  wire wr_port; // write lands on an indirect port
  wire rd_port; // read in progress on an indirect port
  wire [11:0] ptr0; // full pointer value
  reg [11:0] ptr0_next;
  reg [7:0] rd_byte; // selected read byte
  reg [2:0] rd_state_next;
  wire [7:0] mem_rdata; // memory read data, one cycle late

  // outputs straight from flops, both responses tied to okay
  assign S_AXI_AWREADY = aw_ready_reg;
  assign S_AXI_WREADY = w_ready_reg;
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = `CSF_RESP_OKAY;
  assign S_AXI_ARREADY = arready_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign S_AXI_RRESP = `CSF_RESP_OKAY;
  assign TABLE_ADDR = {table_pointer_upper_reg[4:0], table_pointer_high_reg, table_pointer_low_reg};
  assign TABLE_CFG_SEL = table_pointer_upper_reg[`CSF_TABLE_CFG_BIT]; // RL6

  // address decode; anything above the window is treated as empty
  assign wr_idx = aw_addr_reg[`CSF_IDX_MSB:`CSF_IDX_LSB];
  assign rd_idx = ar_addr_reg[`CSF_IDX_MSB:`CSF_IDX_LSB];
  assign wr_mapped = (aw_addr_reg[11:`CSF_ADDR_TOP_LSB] == 2'b00);
  assign rd_mapped = (ar_addr_reg[11:`CSF_ADDR_TOP_LSB] == 2'b00);

  // a write waits while a read owns the pointer, so the two never collide
  assign ar_hs = S_AXI_ARVALID & arready_reg;
  assign wr_fire = ~aw_ready_reg & ~w_ready_reg & ~bvalid_reg & (rd_state_reg == RD_IDLE) & ~ar_hs;
  assign wr_en = wr_fire & wr_mapped & w_lane_reg;
  assign wr_port = wr_en & ((wr_idx == `CSF_IDX_PLAIN_PORT_ZERO) | (wr_idx == `CSF_IDX_AFTER_INC_PORT_ZERO) |
                   (wr_idx == `CSF_IDX_AFTER_DEC_PORT_ZERO)); // RL5
  assign rd_port = (rd_state_reg == RD_MEM) & rd_mapped & ((rd_idx == `CSF_IDX_PLAIN_PORT_ZERO) |
                   (rd_idx == `CSF_IDX_AFTER_INC_PORT_ZERO) | (rd_idx == `CSF_IDX_AFTER_DEC_PORT_ZERO));
  assign ptr0 = {ptr0_high_reg, ptr0_low_reg}; // RL7

  // data memory, addressed by the pointer alone
  csf_dmem #(
    .AW(AW),
    .DEPTH(DEPTH)
  ) u_dmem (
    .clk(SYS_CLK),
    .we(wr_port), // RL5
    .addr(ptr0),
    .wdata(w_byte_reg),
    .rdata(mem_rdata)
  );

  // write channel capture and response
  always @(posedge SYS_CLK)
  begin
    if (!RESETN)
    begin
      aw_ready_reg <= 1'b1;
      w_ready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_byte_reg <= `CSF_RST_BYTE;
      w_lane_reg <= 1'b0;
    end
    else
    begin
      // address and data may come in either order
      if (S_AXI_AWVALID & aw_ready_reg)
      begin
        aw_addr_reg <= S_AXI_AWADDR;
        aw_ready_reg <= 1'b0;
      end
      if (S_AXI_WVALID & w_ready_reg)
      begin
        w_byte_reg <= S_AXI_WDATA[7:0];
        w_lane_reg <= S_AXI_WSTRB[0];
        w_ready_reg <= 1'b0;
      end
      if (wr_fire)
        bvalid_reg <= 1'b1;
      // slots reopen only once the answer is taken
      if (bvalid_reg & S_AXI_BREADY)
      begin
        bvalid_reg <= 1'b0;
        aw_ready_reg <= 1'b1;
        w_ready_reg <= 1'b1;
      end
    end
  end

  // read sequencer next state
  always @*
  begin
    rd_state_next = rd_state_reg;
    case (rd_state_reg)
      // wait for an address
      RD_IDLE: rd_state_next = ar_hs ? RD_MEM : RD_IDLE;
      // memory byte is valid now
      RD_MEM: rd_state_next = RD_RESP;
      // answer stands until taken
      RD_RESP: rd_state_next = S_AXI_RREADY ? RD_IDLE : RD_RESP;
      default: rd_state_next = RD_IDLE;
    endcase
  end

  // read byte select; empty slots give zero, SMALL_VARIANT removes no register
  always @*
  begin
    rd_byte = `CSF_RST_BYTE; // RL1 RL2
    if (rd_mapped)
    begin
      case (rd_idx)
        `CSF_IDX_STACK_TOP_UPPER: rd_byte = stack_top_upper_reg;
        `CSF_IDX_STACK_TOP_HIGH: rd_byte = stack_top_high_reg;
        `CSF_IDX_STACK_TOP_LOW: rd_byte = stack_top_low_reg;
        `CSF_IDX_RETURN_STACK_PTR: rd_byte = {stack_full_flag_reg, stack_underflow_flag_reg, 1'b0, stack_level_reg};
        `CSF_IDX_PC_UPPER_LATCH: rd_byte = pc_upper_latch_reg;
        `CSF_IDX_PC_HIGH_LATCH: rd_byte = pc_high_latch_reg;
        `CSF_IDX_PC_LOW_BYTE: rd_byte = pc_low_byte_reg;
        `CSF_IDX_TABLE_PTR_UPPER: rd_byte = table_pointer_upper_reg;
        `CSF_IDX_TABLE_PTR_HIGH: rd_byte = table_pointer_high_reg;
        `CSF_IDX_TABLE_PTR_LOW: rd_byte = table_pointer_low_reg;
        `CSF_IDX_TABLE_LATCH: rd_byte = table_latch_reg;
        `CSF_IDX_PRODUCT_HIGH: rd_byte = product_high_reg;
        `CSF_IDX_PRODUCT_LOW: rd_byte = product_low_reg;
        `CSF_IDX_INT_CTRL_MAIN: rd_byte = interrupt_control_main_reg;
        `CSF_IDX_INT_CTRL_SECOND: rd_byte = interrupt_control_second_reg;
        `CSF_IDX_INT_CTRL_THIRD: rd_byte = interrupt_control_third_reg;
        `CSF_IDX_PLAIN_PORT_ZERO: rd_byte = mem_rdata; // RL5
        `CSF_IDX_AFTER_INC_PORT_ZERO: rd_byte = mem_rdata; // RL5
        `CSF_IDX_AFTER_DEC_PORT_ZERO: rd_byte = mem_rdata; // RL5
        `CSF_IDX_PTR0_HIGH: rd_byte = {4'h0, ptr0_high_reg}; // RL7
        `CSF_IDX_PTR0_LOW: rd_byte = ptr0_low_reg;
        `CSF_IDX_WORKING_ACC: rd_byte = working_accumulator_reg;
        default: rd_byte = `CSF_RST_BYTE; // RL1
      endcase
    end
  end

  // read channel registers
  always @(posedge SYS_CLK)
  begin
    if (!RESETN)
    begin
      rd_state_reg <= RD_IDLE;
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      ar_addr_reg <= 12'h000;
    end
    else
    begin
      rd_state_reg <= rd_state_next;
      if (ar_hs)
      begin
        ar_addr_reg <= S_AXI_ARADDR;
        arready_reg <= 1'b0;
      end
      if (rd_state_reg == RD_MEM)
      begin
        // narrow data sits low, upper bits zero
        rdata_reg <= {24'h000000, rd_byte};
        rvalid_reg <= 1'b1;
      end
      if ((rd_state_reg == RD_RESP) & S_AXI_RREADY)
      begin
        rvalid_reg <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  // pointer next value; the memory saw the old value this very cycle
  always @*
  begin
    ptr0_next = ptr0;
    if (wr_en & (wr_idx == `CSF_IDX_PTR0_HIGH))
      ptr0_next = {w_byte_reg[3:0] & `CSF_MASK_PTR_HIGH, ptr0_low_reg}; // RL7
    else if (wr_en & (wr_idx == `CSF_IDX_PTR0_LOW))
      ptr0_next = {ptr0_high_reg, w_byte_reg};
    else if ((wr_port & (wr_idx == `CSF_IDX_AFTER_INC_PORT_ZERO)) |
             (rd_port & (rd_idx == `CSF_IDX_AFTER_INC_PORT_ZERO)))
      ptr0_next = ptr0 + `CSF_PTR_STEP; // RL3
    else if ((wr_port & (wr_idx == `CSF_IDX_AFTER_DEC_PORT_ZERO)) |
             (rd_port & (rd_idx == `CSF_IDX_AFTER_DEC_PORT_ZERO)))
      ptr0_next = ptr0 - `CSF_PTR_STEP; // RL4
  end

  // pointer registers
  always @(posedge SYS_CLK)
  begin
    if (!RESETN)
      {ptr0_high_reg, ptr0_low_reg} <= {`CSF_RST_PTR_HIGH, `CSF_RST_BYTE};
    else
      {ptr0_high_reg, ptr0_low_reg} <= ptr0_next;
  end

  // stack flags: a core event in the clearing cycle still sets the flag
  always @(posedge SYS_CLK)
  begin
    if (!RESETN)
    begin
      stack_full_flag_reg <= 1'b0;
      stack_underflow_flag_reg <= 1'b0;
      stack_level_reg <= `CSF_RST_LEVEL;
    end
    else
    begin
      if (STACK_FULL_SET)
        stack_full_flag_reg <= 1'b1;
      else if (wr_en & (wr_idx == `CSF_IDX_RETURN_STACK_PTR) & ~w_byte_reg[`CSF_STACK_FULL_BIT])
        stack_full_flag_reg <= 1'b0;
      if (STACK_UNDER_SET)
        stack_underflow_flag_reg <= 1'b1;
      else if (wr_en & (wr_idx == `CSF_IDX_RETURN_STACK_PTR) & ~w_byte_reg[`CSF_STACK_UNDER_BIT])
        stack_underflow_flag_reg <= 1'b0;
      if (wr_en & (wr_idx == `CSF_IDX_RETURN_STACK_PTR))
        stack_level_reg <= w_byte_reg[4:0] & `CSF_MASK_STACK_LEVEL;
    end
  end

  // plain storage registers; unknown reset values start at zero
  always @(posedge SYS_CLK)
  begin
    if (!RESETN)
    begin
      stack_top_upper_reg <= `CSF_RST_BYTE;
      stack_top_high_reg <= `CSF_RST_BYTE;
      stack_top_low_reg <= `CSF_RST_BYTE;
      pc_upper_latch_reg <= `CSF_RST_BYTE;
      pc_high_latch_reg <= `CSF_RST_BYTE;
      pc_low_byte_reg <= `CSF_RST_BYTE;
      table_pointer_upper_reg <= `CSF_RST_BYTE;
      table_pointer_high_reg <= `CSF_RST_BYTE;
      table_pointer_low_reg <= `CSF_RST_BYTE;
      table_latch_reg <= `CSF_RST_BYTE;
      product_high_reg <= `CSF_RST_BYTE;
      product_low_reg <= `CSF_RST_BYTE;
      interrupt_control_main_reg <= `CSF_RST_BYTE;
      interrupt_control_second_reg <= `CSF_RST_INT_CTRL_SECOND;
      interrupt_control_third_reg <= `CSF_RST_BYTE;
      working_accumulator_reg <= `CSF_RST_BYTE;
    end
    else if (wr_en)
    begin
      // unlisted indices fall through untouched
      case (wr_idx)
        `CSF_IDX_STACK_TOP_UPPER: stack_top_upper_reg <= w_byte_reg & `CSF_MASK_STACK_TOP_UPPER;
        `CSF_IDX_STACK_TOP_HIGH: stack_top_high_reg <= w_byte_reg;
        `CSF_IDX_STACK_TOP_LOW: stack_top_low_reg <= w_byte_reg;
        `CSF_IDX_PC_UPPER_LATCH: pc_upper_latch_reg <= w_byte_reg & `CSF_MASK_PC_UPPER_LATCH;
        `CSF_IDX_PC_HIGH_LATCH: pc_high_latch_reg <= w_byte_reg;
        `CSF_IDX_PC_LOW_BYTE: pc_low_byte_reg <= w_byte_reg;
        `CSF_IDX_TABLE_PTR_UPPER: table_pointer_upper_reg <= w_byte_reg & `CSF_MASK_TABLE_PTR_UPPER; // RL6
        `CSF_IDX_TABLE_PTR_HIGH: table_pointer_high_reg <= w_byte_reg;
        `CSF_IDX_TABLE_PTR_LOW: table_pointer_low_reg <= w_byte_reg;
        `CSF_IDX_TABLE_LATCH: table_latch_reg <= w_byte_reg;
        `CSF_IDX_PRODUCT_HIGH: product_high_reg <= w_byte_reg;
        `CSF_IDX_PRODUCT_LOW: product_low_reg <= w_byte_reg;
        `CSF_IDX_INT_CTRL_MAIN: interrupt_control_main_reg <= w_byte_reg;
        `CSF_IDX_INT_CTRL_SECOND: interrupt_control_second_reg <= w_byte_reg;
        `CSF_IDX_INT_CTRL_THIRD: interrupt_control_third_reg <= w_byte_reg;
        `CSF_IDX_WORKING_ACC: working_accumulator_reg <= w_byte_reg;
        default: working_accumulator_reg <= working_accumulator_reg; // RL1
      endcase
    end
  end

endmodule

// ==== bench/csf_top_chk.sv ====
`timescale 1ns/100ps
module csf_top_chk (
  // clock and reset
  input wire SYS_CLK,
  input wire RESETN,
  // write side
  input wire [11:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  input wire S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  input wire S_AXI_WREADY,
  input wire [1:0] S_AXI_BRESP,
  input wire S_AXI_BVALID,
  input wire S_AXI_BREADY,
  // read side
  input wire [11:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  input wire S_AXI_ARREADY,
  input wire [31:0] S_AXI_RDATA,
  input wire [1:0] S_AXI_RRESP,
  input wire S_AXI_RVALID,
  input wire S_AXI_RREADY,
  // table steering
  input wire [20:0] TABLE_ADDR,
  input wire TABLE_CFG_SEL
);
  reg [7:0] rd_idx_reg; // index of read in flight, 00 if outside
  reg rd_out_reg; // read outside the window
  reg [7:0] wr_idx_reg; // index of write in flight
  reg [7:0] wd_reg; // low data lane of write
  reg ws_reg; // low strobe of write
  reg [11:0] ptr_reg; // shadow of pointer zero
  // shadow pointer, stepped when a port access completes
  always @(posedge SYS_CLK)
  begin
    if (!RESETN)
      ptr_reg <= 12'h000;
    else
    begin
      if (S_AXI_ARVALID && S_AXI_ARREADY)
      begin
        rd_idx_reg <= (|S_AXI_ARADDR[11:10]) ? 8'h00 : S_AXI_ARADDR[9:2];
        rd_out_reg <= |S_AXI_ARADDR[11:10];
      end
      if (S_AXI_AWVALID && S_AXI_AWREADY)
        wr_idx_reg <= (|S_AXI_AWADDR[11:10]) ? 8'h00 : S_AXI_AWADDR[9:2];
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        wd_reg <= S_AXI_WDATA[7:0];
        ws_reg <= S_AXI_WSTRB[0];
      end
      // a refused write moves nothing
      if (S_AXI_BVALID && S_AXI_BREADY && ws_reg)
        case (wr_idx_reg)
          8'he9: ptr_reg[7:0] <= wd_reg;
          8'hea: ptr_reg[11:8] <= wd_reg[3:0];
          8'hee: ptr_reg <= ptr_reg + 12'h001;
          8'hed: ptr_reg <= ptr_reg - 12'h001;
          default: ;
        endcase
      if (S_AXI_RVALID && S_AXI_RREADY)
        case (rd_idx_reg)
          8'hee: ptr_reg <= ptr_reg + 12'h001;
          8'hed: ptr_reg <= ptr_reg - 12'h001;
          default: ;
        endcase
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  sequence ar_taken;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  sequence rd_answer;
    !S_AXI_RVALID ##1 S_AXI_RVALID;
  endsequence
  sequence upper_done;
    S_AXI_BVALID && ws_reg && wr_idx_reg == 8'hf8;
  endsequence
  rd_latency_a: assert property (ar_taken |=> rd_answer)
    else $error("read answer not two cycles after address");
  empty_read_a: assert property (S_AXI_RVALID && (rd_out_reg || rd_idx_reg == 8'hec || rd_idx_reg == 8'heb)
    |-> S_AXI_RDATA == 32'h0) else $error("empty location read nonzero");
  absent_read_a: assert property (S_AXI_RVALID && rd_idx_reg < 8'he8 |-> S_AXI_RDATA == 32'h0)
    else $error("absent register read nonzero");
  ptr_low_a: assert property (S_AXI_RVALID && rd_idx_reg == 8'he9
    |-> S_AXI_RDATA == {24'h0, ptr_reg[7:0]}) else $error("pointer low byte wrong");
  ptr_high_a: assert property (S_AXI_RVALID && rd_idx_reg == 8'hea
    |-> S_AXI_RDATA == {28'h0, ptr_reg[11:8]}) else $error("pointer high byte wrong");
  table_sel_a: assert property (upper_done |-> TABLE_CFG_SEL == wd_reg[5] && TABLE_ADDR[20:16] == wd_reg[4:0])
    else $error("table steering wrong");
  table_addr_a: assert property (S_AXI_BVALID && ws_reg && (wr_idx_reg == 8'hf7 || wr_idx_reg == 8'hf6)
    |-> (wr_idx_reg == 8'hf7 ? TABLE_ADDR[15:8] : TABLE_ADDR[7:0]) == wd_reg)
    else $error("table address byte wrong");
  bvalid_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write answer dropped");
  upper_zero_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0 && S_AXI_RRESP == 2'h0)
    else $error("read upper lanes or response wrong");
endmodule
bind csf_top csf_top_chk csf_top_chk_i (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .S_AXI_AWADDR(S_AXI_AWADDR),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
  .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .TABLE_ADDR(TABLE_ADDR), .TABLE_CFG_SEL(TABLE_CFG_SEL));

// ==== bench/csf_core_evt.sv ====
`timescale 1ns/100ps
module csf_core_evt (
  // clock
  input wire clk,
  // bench request, bit 1 full, bit 0 underflow
  input wire [1:0] fire,
  // stack event pulses
  output reg full_set,
  output reg under_set
);
  // one-cycle pulses, a cycle late like a real stack unit
  always @(posedge clk)
  begin
    full_set <= fire[1];
    under_set <= fire[0];
  end
endmodule

// ==== bench/testbench.sv ====
`timescale 1ns/100ps
module testbench;
  reg clk = 1'h0;
  reg rstn = 1'h0; // active low reset
  reg [11:0] awaddr = 12'h000;
  reg [11:0] araddr = 12'h000;
  reg awv = 1'h0;
  reg wv = 1'h0;
  reg bready = 1'h0;
  reg arv = 1'h0;
  reg rready = 1'h0;
  reg [31:0] wdata = 32'h0;
  reg [3:0] wstrb = 4'h0;
  reg [1:0] fire = 2'h0;
  wire awr, wrr, bv, arr, rv, fs, us, cfg;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [20:0] taddr;
  integer seed = 57;
  integer error_cnt = 0;
  integer num_checks = 0;
  integer i;
  reg [7:0] d;
  reg [31:0] e;
  reg [31:0] expq [$]; // expected read answers, oldest first
  always #20 clk = ~clk;
  csf_top csf_top_i (.SYS_CLK(clk), .RESETN(rstn), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrr),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rready), .STACK_FULL_SET(fs), .STACK_UNDER_SET(us),
    .TABLE_ADDR(taddr), .TABLE_CFG_SEL(cfg));
  csf_core_evt csf_core_evt_i (.clk(clk), .fire(fire), .full_set(fs), .under_set(us));
  // byte address of a register index
  function [11:0] ba(input [7:0] x);
    ba = {2'h0, x, 2'h0};
  endfunction
  // implemented bits of each writable register except f2 and f0, 0 = skip
  function [7:0] msk(input [7:0] x);
    case (x)
      8'hff, 8'hfb, 8'hfc: msk = 8'h1f;
      8'hf8: msk = 8'h3f;
      8'hea: msk = 8'h0f;
      8'he8, 8'he9, 8'hf1, 8'hf3, 8'hf4, 8'hf5, 8'hf6, 8'hf7, 8'hf9, 8'hfa, 8'hfd, 8'hfe: msk = 8'hff;
      default: msk = 8'h00;
    endcase
  endfunction
  // one write, bready raised late so the answer must wait
  task wr(input [11:0] a, input [7:0] dv, input s);
    begin
      @(posedge clk);
      awaddr <= a;
      awv <= 1'h1;
      wdata <= {24'h0, dv};
      wstrb <= {3'h0, s};
      wv <= 1'h1;
      do
      begin
        @(posedge clk);
        if (awr) awv <= 1'h0;
        if (wrr) wv <= 1'h0;
      end
      while ((awv && !awr) || (wv && !wrr));
      while (!bv) @(posedge clk);
      bready <= 1'h1;
      @(posedge clk);
      bready <= 1'h0;
    end
  endtask
  // one read, expectation noted first
  task rd(input [11:0] a, input [31:0] ex);
    begin
      expq.push_back(ex);
      @(posedge clk);
      araddr <= a;
      arv <= 1'h1;
      rready <= 1'h1;
      @(posedge clk);
      while (!arr) @(posedge clk);
      arv <= 1'h0;
      @(posedge clk);
      while (!rv) @(posedge clk);
      rready <= 1'h0;
    end
  endtask
  task done(input [8*8-1:0] n);
    $display("test %0s done", n);
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // compare every read answer with the oldest note
  always @(posedge clk)
  begin
    if (rv === 1'h1 && rready === 1'h1)
    begin
      e = expq.pop_front();
      num_checks = num_checks + 1;
      if (rdata !== e)
      begin
        $display("BAD rdata exp %h seen %h", e, rdata);
        error_cnt = error_cnt + 1;
      end
    end
    // every write answer must be okay
    if (bv === 1'h1 && bready === 1'h1)
    begin
      num_checks = num_checks + 1;
      if (bresp !== 2'h0)
      begin
        $display("BAD bresp exp %h seen %h", 2'h0, bresp);
        error_cnt = error_cnt + 1;
      end
    end
  end
  // hang guard, far beyond the few hundred cycles needed
  initial
  begin
    repeat (5000) @(posedge clk);
    error_cnt = error_cnt + 1;
    finish_test;
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1'h1;
    // reset values, ports skipped so the pointer stays put
    for (i = 8'he8; i <= 8'hff; i = i + 1)
      if (i < 8'hed || i > 8'hef)
        rd(ba(i[7:0]), (i == 8'hf1) ? 32'hff : 32'h0);
    done("reset");
    // random write and read back through the masks
    for (i = 8'he8; i <= 8'hff; i = i + 1)
      if (msk(i[7:0]) != 8'h00)
      begin
        d = $random(seed);
        wr(ba(i[7:0]), d, 1'h1);
        rd(ba(i[7:0]), {24'h0, d & msk(i[7:0])});
      end
    wr(ba(8'hf8), 8'h25, 1'h1);
    wr(ba(8'hf8), 8'h1a, 1'h1);
    done("masks");
    // refused and empty writes change nothing
    wr(ba(8'he8), 8'h5a, 1'h1);
    wr(ba(8'he8), 8'ha5, 1'h0);
    wr({2'h1, 8'he8, 2'h0}, 8'hc3, 1'h1);
    wr(ba(8'he0), 8'h77, 1'h1);
    rd(ba(8'he8), 32'h5a);
    rd({2'h1, 8'he8, 2'h0}, 32'h0);
    rd(ba(8'he0), 32'h0);
    rd(ba(8'hd0), 32'h0);
    done("empty");
    // indirect ports, carry across the byte boundary
    d = $random(seed);
    wr(ba(8'hea), 8'hf0, 1'h1);
    wr(ba(8'he9), 8'hff, 1'h1);
    wr(ba(8'hee), d, 1'h1);
    rd(ba(8'hea), 32'h01);
    rd(ba(8'he9), 32'h00);
    wr(ba(8'hed), ~d, 1'h1);
    rd(ba(8'he9), 32'hff);
    rd(ba(8'hef), {24'h0, d});
    rd(ba(8'hee), {24'h0, d});
    rd(ba(8'hed), {24'h0, ~d});
    rd(ba(8'he9), 32'hff);
    // twelve-bit wrap both ways
    wr(ba(8'hea), 8'h0f, 1'h1);
    wr(ba(8'hee), 8'h3c, 1'h1);
    rd(ba(8'hea), 32'h00);
    wr(ba(8'hef), 8'h96, 1'h1);
    rd(ba(8'hed), 32'h96);
    rd(ba(8'hea), 32'h0f);
    done("ports");
    // stack flags set by the core, underflow cleared by writing zero, full kept by writing one
    wr(ba(8'hfc), 8'h05, 1'h1);
    @(posedge clk);
    fire <= 2'h3;
    @(posedge clk);
    fire <= 2'h0;
    repeat (2) @(posedge clk);
    rd(ba(8'hfc), 32'hc5);
    wr(ba(8'hfc), 8'h83, 1'h1);
    rd(ba(8'hfc), 32'h83);
    done("stack");
    // second reset in mid-run
    @(posedge clk);
    rstn <= 1'h0;
    repeat (2) @(posedge clk);
    rstn <= 1'h1;
    rd(ba(8'hf1), 32'hff);
    rd(ba(8'hfc), 32'h00);
    rd(ba(8'he9), 32'h00);
    done("rereset");
    @(posedge clk);
    finish_test;
  end
endmodule
